/* File: hdl/mxc_pkg.sv */
// Shared constants of the multiplexed transfer channel
package mxc_pkg;
  // Clock and microsecond cycle
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned CYCLE_TIME_PS = 1000000;
  localparam int unsigned CYCLE_CLKS = CYCLE_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned CYCLE_CNT_W = 7;
  // Microsecond cycles per normal transfer, least per burst transfer
  localparam int unsigned NORMAL_XFER_CYCLES = 5;
  localparam int unsigned BURST_XFER_CYCLES = 3;
  // Stop command spacing after a last request, in microseconds
  localparam int unsigned STOP_GAP_US = 25;

  // Controllers and word sizes
  localparam int unsigned NUM_CTRL = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned WORD_W = 16;
  // Standard program level of controller 0 (levels 08 to 17 hex)
  localparam logic [7:0] LEVEL_BASE = 8'h08;
  // Word offsets inside a level's four executive page words
  localparam logic [15:0] ADDR_WORD_OFS = 16'h0001;
  localparam logic [15:0] MODE_WORD_OFS = 16'h0002;
  localparam int unsigned LEVEL_SHIFT = 2;

  // Mode/count word fields
  localparam int unsigned MODE_DIR_BIT = 15;
  localparam int unsigned MODE_BURST_BIT = 14;
  localparam int unsigned MODE_WORD_BIT = 13;
  localparam int unsigned COUNT_W = 13;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 13'h1FFF;

  // Write queue entry: address, data, byte enables
  localparam int unsigned WQ_W = 34;
  localparam int unsigned WQ_DEPTH = 16;
  localparam logic [1:0] BE_WORD = 2'h3;
  localparam logic [1:0] BE_RIGHT = 2'h1;
  localparam logic [1:0] BE_LEFT = 2'h2;

  // Sequencer states
  typedef enum logic [3:0] {
    MXC_IDLE = 4'h0,
    MXC_RD_ADDR = 4'h1,
    MXC_RD_MODE = 4'h2,
    MXC_XFER = 4'h3,
    MXC_STORE = 4'h4,
    MXC_BWAIT = 4'h5,
    MXC_WB = 4'h6,
    MXC_IRQ = 4'h7
  } mxc_state_e;
endpackage

/* File: hdl/mxc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// Small first-in first-out store with registered read data
module mxc_fifo #(
  parameter int unsigned WIDTH = 34,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage array
  logic [PW-1:0] wptr_q;             // Write pointer
  logic [PW-1:0] rptr_q;             // Read pointer
  logic [CW-1:0] cnt_q;              // Words held in the array
  logic out_valid_q;                 // Output register holds a word
  logic [WIDTH-1:0] out_data_q;      // Output register

  // Push and pop decisions
  wire logic push = in_valid && in_ready;
  wire logic load = (cnt_q != '0) && (!out_valid_q || out_ready);

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // Array write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  // Pointers, fill count and output register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= PW'(wptr_q + 1'b1);
      end
      if (load) begin
        rptr_q <= PW'(rptr_q + 1'b1);
        out_data_q <= mem_q[rptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      cnt_q <= CW'(cnt_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, load});
    end
  end
endmodule // mxc_fifo
`default_nettype wire

/* File: hdl/mxc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Stored words alone start nothing
// - Nonzero length request gets one transfer
// - Zero length request raises level interrupt
// - Normal transfer takes five microsecond cycles
// - Higher priority pending requests served first
// - Start within longest instruction plus cycle
// - Channel never flags overrun timing errors
// - Burst holds program execution until done
// - Burst three cycles, waits add microseconds
// - Missing acknowledge ends the record
// - Every transfer decrements length, advances address after word or right byte
// - Block length counts up to 8191
// - Byte parity picks half and address step
// - Normal writes back, burst holds words
// - Only count field decrements, mode kept
// - End of record requests level interrupt
module mxc_channel (
  input wire logic clk_sys,
  input wire logic resetn,
  // Service request pins of the sixteen controllers
  input wire logic [mxc_pkg::NUM_CTRL-1:0] srv_req,
  // Processor handshake
  output logic chan_idle_req,
  input wire logic cpu_idle_grant,
  output logic cpu_hold,
  output logic [mxc_pkg::NUM_CTRL-1:0] level_irq,
  // Memory read port
  output logic mem_rd_req,
  output logic [mxc_pkg::WORD_W-1:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [mxc_pkg::WORD_W-1:0] mem_rd_data,
  // Memory write port fed from the write queue
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [mxc_pkg::WORD_W-1:0] mem_wr_addr,
  output logic [mxc_pkg::WORD_W-1:0] mem_wr_data,
  output logic [1:0] mem_wr_be,
  // Programmed I/O bus side
  output logic [7:0] io_dev_addr,
  output logic io_xfer_strobe,
  output logic io_xfer_input,
  output logic [mxc_pkg::WORD_W-1:0] io_dout,
  output logic io_oe,
  input wire logic [mxc_pkg::WORD_W-1:0] io_din,
  input wire logic io_ack,
  // Status
  output logic chan_busy,
  output logic [mxc_pkg::IDX_W-1:0] chan_device
);
  import mxc_pkg::*;

  // Pin synchronisers
  logic [NUM_CTRL-1:0] req_m_q;
  logic [NUM_CTRL-1:0] req_s_q;
  logic ack_m_q;
  logic ack_s_q;
  logic [WORD_W-1:0] din_m_q;
  logic [WORD_W-1:0] din_s_q;

  // Microsecond divider
  logic [CYCLE_CNT_W-1:0] div_q;
  logic tick_us;

  // Sequencer
  mxc_state_e state_q;
  mxc_state_e state_d;
  logic op_done_q;                   // Work of the current cycle finished
  logic step_q;                      // Second write of the write back
  logic [IDX_W-1:0] dev_q;           // Device in service
  logic [NUM_CTRL-1:0] armed_q;      // Request seen low since last service
  logic [WORD_W-1:0] addr_q;         // Working transfer address word
  logic [WORD_W-1:0] mode_q;         // Working mode/count word
  logic [WORD_W-1:0] data_q;         // Data register
  logic acked_q;                     // Controller acknowledged transfer
  logic term_q;                      // Record ended by the controller
  logic rd_req_q;
  logic [WORD_W-1:0] rd_addr_q;
  logic [NUM_CTRL-1:0] irq_q;

  // Write queue port
  logic wq_valid;
  logic wq_ready;
  logic [WQ_W-1:0] wq_data;
  logic wq_out_valid;
  logic [WQ_W-1:0] wq_out_data;
  logic wq_empty_q;

  // Two flops on every pin from the controllers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      req_m_q <= '0;
      req_s_q <= '0;
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      req_m_q <= srv_req;
      req_s_q <= req_m_q;
      ack_m_q <= io_ack;
      ack_s_q <= ack_m_q;
      din_m_q <= io_din;
      din_s_q <= din_m_q;
    end
  end

  // One microsecond machine cycle enable
  assign tick_us = (div_q == CYCLE_CNT_W'(CYCLE_CLKS - 1));
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (tick_us) begin
      div_q <= '0;
    end else begin
      div_q <= CYCLE_CNT_W'(div_q + 1'b1);
    end
  end

  // A request counts only after it was low once since last service
  // nothing runs until a controller raises its request
  logic [NUM_CTRL-1:0] pend;
  logic [IDX_W-1:0] sel_idx;         // Highest priority pending controller
  logic take_any;                    // Service taken at this edge
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CTRL; gi++) begin : g_arm
      assign pend[gi] = req_s_q[gi] && armed_q[gi];
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          armed_q[gi] <= 1'b1;
        end else if (!req_s_q[gi]) begin
          armed_q[gi] <= 1'b1;
        end else if (take_any && sel_idx == IDX_W'(gi)) begin
          armed_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Lowest index is highest relative priority
  always_comb begin
    sel_idx = '0;
    for (int i = NUM_CTRL - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel_idx = IDX_W'(i);
      end
    end
  end

  // Mode decode of the working mode/count word
  wire logic mode_in = mode_q[MODE_DIR_BIT];
  wire logic mode_burst = mode_q[MODE_BURST_BIT];
  wire logic mode_word = mode_q[MODE_WORD_BIT];
  wire logic [COUNT_W-1:0] count = mode_q[COUNT_W-1:0];
  wire logic byte_right = count[0];
  wire logic count_zero = (count == '0);

  // Service starts at the idle state the processor grants
  assign take_any = (state_q == MXC_IDLE) && cpu_idle_grant && (|pend);
  wire logic burst_next = (state_q == MXC_BWAIT) && pend[dev_q] && tick_us;

  // Level and executive page addresses of the device in service
  wire logic [7:0] level = 8'(LEVEL_BASE + {4'h0, dev_q});
  wire logic [WORD_W-1:0] page_base = WORD_W'({8'h00, level} << LEVEL_SHIFT);

  // Updated words after one request
  wire logic [WORD_W-1:0] addr_step = (mode_word || byte_right) ? 16'h0001 : 16'h0000;
  wire logic [WORD_W-1:0] addr_next = WORD_W'(addr_q + addr_step);
  wire logic [COUNT_W-1:0] count_next = COUNT_W'(count - 1'b1);
  wire logic [WORD_W-1:0] mode_next = {mode_q[WORD_W-1:COUNT_W], count_next};

  // Byte placement of input data and choice of output byte
  wire logic [7:0] in_byte = din_s_q[7:0];
  wire logic [WORD_W-1:0] in_word = mode_word ? din_s_q :
                                   (byte_right ? {8'h00, in_byte} : {in_byte, 8'h00});
  wire logic [1:0] in_be = mode_word ? BE_WORD : (byte_right ? BE_RIGHT : BE_LEFT);
  wire logic [WORD_W-1:0] out_word = (mode_word || byte_right) ? data_q :
                                    {8'h00, data_q[15:8]};

  // Which words go to the write queue in each state
  wire logic store_data = (state_q == MXC_STORE) && mode_in && acked_q && !op_done_q;
  wire logic wb_push = (state_q == MXC_WB) && !op_done_q;
  assign wq_valid = store_data || wb_push;
  assign wq_data = store_data ? {addr_q, in_word, in_be} :
                   (step_q ? {16'(page_base + MODE_WORD_OFS), mode_q, BE_WORD} :
                             {16'(page_base + ADDR_WORD_OFS), addr_q, BE_WORD});

  // Read of control words waits for queued writes to land
  wire logic rd_idle = !rd_req_q && wq_empty_q && !wq_out_valid;
  wire logic need_out_rd = (state_q == MXC_XFER) && !mode_in;

  // Next state; read, transfer, store and write back states end on a microsecond tick
  always_comb begin
    state_d = state_q;
    case (state_q)
      MXC_IDLE: begin
        if (take_any) begin
          state_d = MXC_RD_ADDR;
        end
      end
      MXC_RD_ADDR: begin
        if (op_done_q && tick_us) begin
          state_d = MXC_RD_MODE;
        end
      end
      MXC_RD_MODE: begin
        if (op_done_q && tick_us) begin
          state_d = count_zero ? MXC_IRQ : MXC_XFER;
        end
      end
      MXC_XFER: begin
        if (op_done_q && tick_us) begin
          state_d = MXC_STORE;
        end
      end
      MXC_STORE: begin
        if (op_done_q && tick_us) begin
          state_d = mode_burst ? MXC_BWAIT : MXC_WB;
        end
      end
      MXC_BWAIT: begin
        if (count_zero || term_q) begin
          state_d = MXC_WB;
        end else if (burst_next) begin
          state_d = MXC_XFER;
        end
      end
      MXC_WB: begin
        if (op_done_q && step_q && tick_us) begin
          state_d = (count_zero || term_q) ? MXC_IRQ : MXC_IDLE;
        end
      end
      MXC_IRQ: begin
        state_d = MXC_IDLE;
      end
      default: begin
        state_d = MXC_IDLE;
      end
    endcase
  end

  // State register and per state progress flags
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= MXC_IDLE;
      op_done_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        op_done_q <= 1'b0;
        step_q <= 1'b0;
      end else if (state_q == MXC_WB && wq_ready && !op_done_q) begin
        step_q <= 1'b1;
        op_done_q <= step_q;
      end else if (state_q == MXC_STORE && (wq_ready || !store_data)) begin
        op_done_q <= 1'b1;
      end else if ((state_q == MXC_RD_ADDR || state_q == MXC_RD_MODE) && mem_rd_ack) begin
        op_done_q <= 1'b1;
      end else if (state_q == MXC_XFER && !need_out_rd) begin
        op_done_q <= 1'b1;
      end else if (state_q == MXC_XFER && mem_rd_ack) begin
        op_done_q <= 1'b1;
      end
    end
  end

  // Memory read requests for control words and output data
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (mem_rd_ack) begin
      rd_req_q <= 1'b0;
    end else if (rd_idle && !op_done_q) begin
      if (state_q == MXC_RD_ADDR) begin
        rd_req_q <= 1'b1;
        rd_addr_q <= WORD_W'(page_base + ADDR_WORD_OFS);
      end else if (state_q == MXC_RD_MODE) begin
        rd_req_q <= 1'b1;
        rd_addr_q <= WORD_W'(page_base + MODE_WORD_OFS);
      end else if (need_out_rd) begin
        rd_req_q <= 1'b1;
        rd_addr_q <= addr_q;
      end
    end
  end

  // Working words, data register and termination
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dev_q <= '0;
      addr_q <= '0;
      mode_q <= '0;
      data_q <= '0;
      acked_q <= 1'b0;
      term_q <= 1'b0;
    end else begin
      if (take_any) begin
        dev_q <= sel_idx;
        term_q <= 1'b0;
      end
      if (mem_rd_ack && state_q == MXC_RD_ADDR) begin
        addr_q <= mem_rd_data;
      end
      if (mem_rd_ack && state_q == MXC_RD_MODE) begin
        mode_q <= mem_rd_data;
      end
      if (mem_rd_ack && state_q == MXC_XFER) begin
        data_q <= mem_rd_data;
      end
      if (state_q == MXC_XFER && tick_us && op_done_q) begin
        acked_q <= ack_s_q;
        term_q <= !ack_s_q;
      end
      // Address and count move even without acknowledge
      if (state_q == MXC_STORE && tick_us && op_done_q) begin
        addr_q <= addr_next;
        mode_q <= mode_next;
      end
    end
  end

  // Level interrupt pulse on zero length or ended record
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_q <= '0;
    end else begin
      irq_q <= '0;
      if (state_q == MXC_IRQ) begin
        irq_q[dev_q] <= 1'b1;
      end
    end
  end

  // Bus outputs registered; overrun is left to the controller
  logic strobe_q;
  logic oe_q;
  logic [WORD_W-1:0] dout_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strobe_q <= 1'b0;
      oe_q <= 1'b0;
      dout_q <= '0;
    end else begin
      strobe_q <= (state_q == MXC_XFER) && op_done_q;
      oe_q <= (state_q == MXC_XFER) && op_done_q && !mode_in;
      dout_q <= out_word;
    end
  end

  // Empty flag of the write queue, tracked beside it
  logic [4:0] wq_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wq_cnt_q <= '0;
      wq_empty_q <= 1'b1;
    end else begin
      wq_cnt_q <= 5'(wq_cnt_q + {4'h0, wq_valid && wq_ready}
                  - {4'h0, wq_out_valid && mem_wr_ready});
      wq_empty_q <= (5'(wq_cnt_q + {4'h0, wq_valid && wq_ready}
                  - {4'h0, wq_out_valid && mem_wr_ready}) == 5'h00);
    end
  end

  // Write queue toward memory; a stalled memory stalls the sequencer
  mxc_fifo #(
    .WIDTH(WQ_W),
    .DEPTH(WQ_DEPTH)
  ) u_wq (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(wq_valid),
    .in_ready(wq_ready),
    .in_data(wq_data),
    .out_valid(wq_out_valid),
    .out_ready(mem_wr_ready),
    .out_data(wq_out_data)
  );

  // Output assignments
  assign chan_idle_req = (state_q == MXC_IDLE) && (|pend);
  assign cpu_hold = mode_burst && (state_q == MXC_XFER || state_q == MXC_STORE
                    || state_q == MXC_BWAIT || (state_q == MXC_WB && mode_burst));
  assign level_irq = irq_q;
  assign mem_rd_req = rd_req_q;
  assign mem_rd_addr = rd_addr_q;
  assign mem_wr_valid = wq_out_valid;
  assign mem_wr_addr = wq_out_data[33:18];
  assign mem_wr_data = wq_out_data[17:2];
  assign mem_wr_be = wq_out_data[1:0];
  assign io_dev_addr = level;
  assign io_xfer_strobe = strobe_q;
  assign io_xfer_input = mode_in;
  assign io_dout = dout_q;
  assign io_oe = oe_q;
  assign chan_busy = (state_q != MXC_IDLE);
  assign chan_device = dev_q;
endmodule // mxc_channel
`default_nettype wire

/* File: bench/mxc_channel_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checks of the transfer channel
module mxc_channel_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic chan_idle_req,
  input wire logic cpu_idle_grant,
  input wire logic cpu_hold,
  input wire logic [mxc_pkg::NUM_CTRL-1:0] level_irq,
  input wire logic mem_rd_req,
  input wire logic [mxc_pkg::WORD_W-1:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire logic [mxc_pkg::WORD_W-1:0] mem_wr_addr,
  input wire logic [mxc_pkg::WORD_W-1:0] mem_wr_data,
  input wire logic [7:0] io_dev_addr,
  input wire logic io_xfer_strobe,
  input wire logic io_xfer_input,
  input wire logic io_oe,
  input wire logic chan_busy,
  input wire logic [mxc_pkg::IDX_W-1:0] chan_device
);
  import mxc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Service is taken while idle
  sequence s_taken;
    chan_idle_req && cpu_idle_grant;
  endsequence
  // A memory read still waits
  sequence s_rd_wait;
    mem_rd_req && !mem_rd_ack;
  endsequence
  a_start_prompt: assert property (s_taken |=> chan_busy)
    else $error("service not started after grant");
  a_start_cause: assert property ($rose(chan_busy) |-> $past(chan_idle_req))
    else $error("channel started without a pending request");
  a_rd_held: assert property (s_rd_wait |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("memory read dropped or moved before ack");
  a_wr_held: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("memory write changed while stalled");
  a_irq_single: assert property (|level_irq |-> $onehot(level_irq) ##1 level_irq == 16'h0000)
    else $error("level interrupt not a single one-cycle pulse");
  a_irq_device: assert property (|level_irq |-> level_irq == (16'h0001 << chan_device))
    else $error("level interrupt on wrong controller");
  a_dev_addr: assert property (io_dev_addr == LEVEL_BASE + {4'h0, chan_device})
    else $error("device address not tied to priority level");
  a_strobe_busy: assert property (io_xfer_strobe |-> chan_busy)
    else $error("transfer strobe outside service");
  a_strobe_us: assert property ($rose(io_xfer_strobe) |-> ##[1:100] !io_xfer_strobe)
    else $error("transfer strobe longer than one microsecond");
  a_oe_dir: assert property (io_oe |-> !io_xfer_input && chan_busy)
    else $error("data driven on an input transfer");
  a_hold_same: assert property (cpu_hold |=> !cpu_hold || $stable(chan_device))
    else $error("other controller served during burst");
endmodule // mxc_channel_props
bind mxc_channel mxc_channel_props u_props (.clk_sys(clk_sys), .resetn(resetn),
  .chan_idle_req(chan_idle_req), .cpu_idle_grant(cpu_idle_grant), .cpu_hold(cpu_hold),
  .level_irq(level_irq), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
  .mem_rd_ack(mem_rd_ack), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .io_dev_addr(io_dev_addr),
  .io_xfer_strobe(io_xfer_strobe), .io_xfer_input(io_xfer_input), .io_oe(io_oe),
  .chan_busy(chan_busy), .chan_device(chan_device));
`default_nettype wire

/* File: bench/mxc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Peripheral controllers on the shared I/O bus
module mxc_ctrl_model (
  input wire logic clk_sys,
  input wire logic ack_en,
  input wire logic [7:0] ack_dly,
  input wire logic [7:0] io_dev_addr,
  input wire logic io_xfer_strobe,
  input wire logic io_oe,
  input wire logic [mxc_pkg::WORD_W-1:0] io_dout,
  output logic [mxc_pkg::WORD_W-1:0] io_din,
  output logic io_ack,
  output logic [mxc_pkg::WORD_W-1:0] out_word
);
  import mxc_pkg::*;
  logic [7:0] wait_q; // Cycles since strobe rose
  logic [7:0] slot; // Offset inside the group
  logic mine; // Address belongs to the group
  logic [7:0] dbyte; // Byte a controller supplies
  assign slot = io_dev_addr - LEVEL_BASE;
  assign mine = slot < 8'h10;
  assign dbyte = io_dev_addr + 8'h30;
  initial begin
    io_din = 16'h0000;
    io_ack = 1'b0;
    wait_q = 8'h00;
    out_word = 16'h0000;
  end
  // Answer at the falling edge; no overrun status kept
  always @(negedge clk_sys) begin
    if (io_xfer_strobe && mine) begin
      wait_q <= wait_q + 8'h01;
      io_din <= {dbyte, dbyte};
      io_ack <= ack_en && (wait_q >= ack_dly);
    end else begin
      // Released data lines wander
      wait_q <= 8'h00;
      io_din <= ~io_din;
      io_ack <= 1'b0;
    end
    if (io_xfer_strobe && io_oe) begin
      out_word <= io_dout;
    end
  end
endmodule // mxc_ctrl_model
`default_nettype wire

/* File: bench/mxc_channel_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the transfer channel
module mxc_channel_tb;
  import mxc_pkg::*;
  typedef struct packed {
    logic [3:0] dev; // Controller index
    logic [15:0] aw; // Address word before
    logic [15:0] mw; // Mode word before
    logic [4:0] f; // Ack, stall, data check, irq, strobe
    logic [15:0] exp_d; // Stored or sent word
    logic [15:0] exp_aw; // Address word after
    logic [15:0] exp_mw; // Mode word after
  } mxc_row_s;
  localparam mxc_row_s ROWS [8] = '{
    '{4'h0, 16'h0100, 16'hA002, 5'h15, 16'h3838, 16'h0101, 16'hA001},
    '{4'h1, 16'h0110, 16'h9FFF, 5'h15, 16'h0039, 16'h0111, 16'h9FFE},
    '{4'h2, 16'h0120, 16'h8002, 5'h15, 16'h3A00, 16'h0120, 16'h8001},
    '{4'h3, 16'h0130, 16'h2001, 5'h17, 16'h1234, 16'h0131, 16'h2000},
    '{4'h4, 16'h0140, 16'hE001, 5'h17, 16'h3C3C, 16'h0141, 16'hE000},
    '{4'h5, 16'h0150, 16'hA005, 5'h03, 16'h0000, 16'h0151, 16'hA004},
    '{4'h6, 16'h0160, 16'hA000, 5'h12, 16'h0000, 16'h0000, 16'h0000},
    '{4'hF, 16'h01F0, 16'hA003, 5'h1D, 16'h4747, 16'h01F1, 16'hA002}};
  logic clk_sys, resetn, cpu_idle_grant, chan_idle_req, cpu_hold, mem_rd_req, mem_rd_ack;
  logic mem_wr_valid, mem_wr_ready, io_xfer_strobe, io_xfer_input, io_oe, io_ack, chan_busy;
  logic [15:0] srv_req, level_irq, mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
  logic [15:0] io_dout, io_din, out_word, irq_seen;
  logic [1:0] mem_wr_be; // Write byte enables
  logic [7:0] io_dev_addr, ack_dly;
  logic [3:0] chan_device, first_dev;
  logic ack_en, wr_stall, stb_seen, hold_seen; // Controls and sticky flags
  logic [15:0] mem [0:511]; // Memory behind the channel
  int errors = 0;
  int check_count = 0;
  int busy_cyc;
  mxc_channel dut (.clk_sys(clk_sys), .resetn(resetn), .srv_req(srv_req),
    .chan_idle_req(chan_idle_req), .cpu_idle_grant(cpu_idle_grant), .cpu_hold(cpu_hold),
    .level_irq(level_irq), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_be(mem_wr_be), .io_dev_addr(io_dev_addr), .io_xfer_strobe(io_xfer_strobe),
    .io_xfer_input(io_xfer_input), .io_dout(io_dout), .io_oe(io_oe), .io_din(io_din),
    .io_ack(io_ack), .chan_busy(chan_busy), .chan_device(chan_device));
  mxc_ctrl_model u_ctrl (.clk_sys(clk_sys), .ack_en(ack_en), .ack_dly(ack_dly),
    .io_dev_addr(io_dev_addr), .io_xfer_strobe(io_xfer_strobe), .io_oe(io_oe),
    .io_dout(io_dout), .io_din(io_din), .io_ack(io_ack), .out_word(out_word));
  // Clock of 100 MHz
  always #5 clk_sys = ~clk_sys;
  // Memory answers off the sampling edge
  always @(negedge clk_sys) begin
    mem_rd_ack <= mem_rd_req && !mem_rd_ack;
    mem_rd_data <= mem_rd_req ? mem[mem_rd_addr[8:0]] : ~mem_rd_data;
    mem_wr_ready <= !wr_stall;
  end
  // Accepted writes land and events are remembered
  always @(posedge clk_sys) begin
    if (mem_wr_valid && mem_wr_ready && mem_wr_be[0]) mem[mem_wr_addr[8:0]][7:0] <= mem_wr_data[7:0];
    if (mem_wr_valid && mem_wr_ready && mem_wr_be[1]) mem[mem_wr_addr[8:0]][15:8] <= mem_wr_data[15:8];
    irq_seen <= irq_seen | level_irq;
    stb_seen <= stb_seen | io_xfer_strobe;
    hold_seen <= hold_seen | cpu_hold;
  end
  task automatic chk16(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // One service from start to idle; request dropped once satisfied
  task automatic serve();
    int n;
    n = 0;
    busy_cyc = 0;
    irq_seen = 16'h0000;
    stb_seen = 1'b0;
    hold_seen = 1'b0;
    while (!chan_busy && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    first_dev = chan_device;
    while (chan_busy && n < 4000) begin
      if (stb_seen || irq_seen[first_dev]) srv_req[first_dev] = 1'b0;
      @(negedge clk_sys);
      n++;
      busy_cyc++;
    end
    chk1("served", n < 4000 && busy_cyc > 0, 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    mxc_row_s r;
    logic [8:0] ca;
    clk_sys = 1'b0;
    resetn = 1'b0;
    srv_req = 16'h0000;
    cpu_idle_grant = 1'b1;
    mem_rd_ack = 1'b0;
    mem_rd_data = 16'h0000;
    mem_wr_ready = 1'b1;
    ack_en = 1'b1;
    ack_dly = 8'h00;
    wr_stall = 1'b0;
    stb_seen = 1'b0;
    for (int k = 0; k < 512; k++) mem[k] = 16'h0000;
    mem[9'h021] = 16'h0100;
    mem[9'h022] = 16'hA002;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    chk16("device address", {8'h00, io_dev_addr}, 16'h0008);
    chk16("irq at reset", level_irq, 16'h0000);
    repeat (300) @(negedge clk_sys);
    chk1("no start", chan_busy | mem_rd_req | stb_seen, 1'b0);
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      ca = 9'h021 + {3'h0, r.dev, 2'h0};
      mem[ca] = r.aw;
      mem[ca + 9'h001] = r.mw;
      mem[r.aw[8:0]] = r.mw[15] ? 16'h0000 : r.exp_d;
      ack_en = r.f[4];
      wr_stall = r.f[3];
      ack_dly = 8'(i * 4);
      srv_req[r.dev] = 1'b1;
      serve();
      wr_stall = 1'b0;
      repeat (STOP_GAP_US * CYCLE_CLKS) @(negedge clk_sys);
      chk1("level irq", irq_seen[r.dev], r.f[1]);
      chk1("strobe", stb_seen, r.f[0]);
      chk1("burst hold", hold_seen, r.mw[14]);
      if (r.f[0]) chk16("address word", mem[ca], r.exp_aw);
      if (r.f[0]) chk16("mode word", mem[ca + 9'h001], r.exp_mw);
      if (r.f[2]) chk16("data", r.mw[15] ? mem[r.aw[8:0]] : out_word, r.exp_d);
      if (i == 0) chk1("five cycles", busy_cyc > 400 && busy_cyc <= 600, 1'b1);
    end
    cpu_idle_grant = 1'b0;
    srv_req = 16'h000A;
    repeat (150) @(negedge clk_sys);
    chk1("idle request", chan_idle_req, 1'b1);
    chk1("held off", chan_busy, 1'b0);
    cpu_idle_grant = 1'b1;
    serve();
    chk16("first device", {12'h000, first_dev}, 16'h0001);
    serve();
    chk16("second device", {12'h000, first_dev}, 16'h0003);
    // Pulse lands in the sticky flag one edge after busy drops
    repeat (2) @(negedge clk_sys);
    chk1("zero length irq", irq_seen[3], 1'b1);
    srv_req = 16'h0000;
    repeat (20) @(negedge clk_sys);
    give_verdict();
  end
endmodule // mxc_channel_tb
`default_nettype wire
